/* File: inc/kbrom_map.vh */
`ifndef KBROM_MAP_VH
`define KBROM_MAP_VH
// address decode
`define KBROM_ADDR_W        24
`define KBROM_KBD_REGION    8'h42
`define KBROM_ROM_TOP_STD   24'h01_FFFF
`define KBROM_ROM_TOP_EXT   24'h03_FFFF
// bit position of the register-select source in the host address
`define KBROM_RS_BIT        1
// peripheral reset timing
`define KBROM_CLK_MHZ       250
`define KBROM_RESET_US      25
`define KBROM_RESET_CYCLES  (`KBROM_RESET_US * `KBROM_CLK_MHZ)
`define KBROM_CNT_W         13
`endif

/* File: verilog/kbrom_decode.v */
// Behaviour
// - register select is latched host address bit 1
// - peripheral reset low 25 us after reset
// - keyboard select for any 42XXXX cycle
// - keyboard select strapped low stays tri-stated
// - keyboard strap disables all keyboard logic
// - rom select on reads 000000-01FFFF only
// - extended rom bit widens range to 03FFFF
// - rom select strapped low stays tri-stated
// - rom strap disables boot rom logic
// - separate read and write keyboard strobes
// - test mask input forces write strobe high in test mode
`timescale 1ns/1ps
`include "kbrom_map.vh"

module kbrom_decode #(
   parameter RESET_CYCLES = `KBROM_RESET_CYCLES
)(
   input  wire                      core_clk,
   input  wire                      rst,
   input  wire                      powerup_reset_n,
   input  wire                      sys_reset_n,
   input  wire [`KBROM_ADDR_W-1:0]  busAddr,
   input  wire                      busCycle,
   input  wire                      busRead,
   input  wire                      extRomDecode,
   input  wire                      testMode_n,
   input  wire                      strobeMask,
   input  wire                      kbdCs_n_in,
   input  wire                      romCs_n_in,
   output reg                       kbdCs_n_out,
   output reg                       kbdCs_n_oe_n,
   output reg                       romCs_n_out,
   output reg                       romCs_n_oe_n,
   output reg                       kbd_reg_select,
   output reg                       kbd_read_strobe_n,
   output reg                       kbd_write_strobe_n,
   output reg                       periph_reset_n
);

   // ****************************************************************
   // strap capture
   // ****************************************************************
   // a strap counts as low only if it stayed low through the power-up
   // reset after its first edge; any later high sample clears the flag
   localparam NUM_SEL = 2;
   localparam SEL_KBD = 0;
   localparam SEL_ROM = 1;

   reg                 puActive_ff;
   wire                puActive = ~powerup_reset_n;
   wire [NUM_SEL-1:0]  strapPin;
   wire [NUM_SEL-1:0]  selOff;
   wire                kbdOff;
   wire                romOff;

   assign strapPin[SEL_KBD] = kbdCs_n_in;
   assign strapPin[SEL_ROM] = romCs_n_in;

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         puActive_ff <= 1'b0;
      end
      else
      begin
         puActive_ff <= puActive;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_SEL; g = g + 1)
      begin : g_strap
         reg lowSeen_ff;
         reg off_ff;

         always @(posedge core_clk or posedge rst)
         begin
            if (rst)
            begin
               lowSeen_ff <= 1'b1;
            end
            else if (puActive)
            begin
               // on the first reset edge our own driver still holds the
               // pin, so that sample is skipped and the flag only armed
               if (puActive_ff)
               begin
                  lowSeen_ff <= lowSeen_ff & ~strapPin[g];
               end
               else
               begin
                  lowSeen_ff <= 1'b1;
               end
            end
         end

         // the verdict stands until the next power-up reset ends
         always @(posedge core_clk or posedge rst)
         begin
            if (rst)
            begin
               off_ff <= 1'b0;
            end
            else if (!puActive && puActive_ff)
            begin
               off_ff <= lowSeen_ff;
            end
         end

         assign selOff[g] = off_ff;
      end
   endgenerate

   assign kbdOff = selOff[SEL_KBD];
   assign romOff = selOff[SEL_ROM];

   // ****************************************************************
   // peripheral reset stretcher
   // ****************************************************************
   reg [`KBROM_CNT_W-1:0] rstCnt_ff;
   wire                   anyReset = puActive | ~sys_reset_n;

   wire                   cntBusy  = (rstCnt_ff != {`KBROM_CNT_W{1'b0}});

   // the count restarts on every reset edge, so a long reset input
   // always gets the full stretch after it ends
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rstCnt_ff <= {`KBROM_CNT_W{1'b0}};
      end
      else if (anyReset)
      begin
         rstCnt_ff <= RESET_CYCLES[`KBROM_CNT_W-1:0];
      end
      else if (cntBusy)
      begin
         rstCnt_ff <= rstCnt_ff - 1'b1;
      end
   end

   // held low while any reset is active and for the full count after
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         periph_reset_n <= 1'b0;
      end
      else
      begin
         periph_reset_n <= ~(anyReset | cntBusy);
      end
   end

   // ****************************************************************
   // decode and strobes
   // ****************************************************************
   wire kbdRegion = (busAddr[`KBROM_ADDR_W-1:16] == `KBROM_KBD_REGION);
   wire kbdHit = busCycle & ~kbdOff & kbdRegion;
   wire [`KBROM_ADDR_W-1:0] romTop = extRomDecode ? `KBROM_ROM_TOP_EXT
                                                  : `KBROM_ROM_TOP_STD;
   wire romHit = busCycle & busRead & ~romOff & (busAddr <= romTop);
   wire wrMask = ~testMode_n & strobeMask;

   // ****************************************************************
   // select pin drivers
   // ****************************************************************
   // tri-state through power-up reset and one edge after it, so the
   // driver never turns on before the strap verdict has settled
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         kbdCs_n_oe_n <= 1'b1;
      end
      else
      begin
         kbdCs_n_oe_n <= kbdOff | puActive | puActive_ff;
      end
   end

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         romCs_n_oe_n <= 1'b1;
      end
      else
      begin
         romCs_n_oe_n <= romOff | puActive | puActive_ff;
      end
   end

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         kbdCs_n_out <= 1'b1;
      end
      else
      begin
         kbdCs_n_out <= ~kbdHit;
      end
   end

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         romCs_n_out <= 1'b1;
      end
      else
      begin
         romCs_n_out <= ~romHit;
      end
   end

   // ****************************************************************
   // keyboard register select and strobes
   // ****************************************************************
   // latch only at a select so the address holds past the strobe
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         kbd_reg_select <= 1'b0;
      end
      else if (kbdHit)
      begin
         kbd_reg_select <= busAddr[`KBROM_RS_BIT];
      end
   end

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         kbd_read_strobe_n <= 1'b1;
      end
      else
      begin
         kbd_read_strobe_n <= ~(kbdHit & busRead);
      end
   end

   // the mask only ever raises the strobe, so test mode cannot
   // create a write that the decode did not ask for
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         kbd_write_strobe_n <= 1'b1;
      end
      else
      begin
         kbd_write_strobe_n <= ~(kbdHit & ~busRead) | wrMask;
      end
   end

endmodule // kbrom_decode

/* File: test/kbrom_decode_assertions.sv */
`timescale 1ns/1ps
// ****
// decode checker
// ****
module kbrom_decode_assertions #(parameter RESET_CYCLES = 8)(
   input wire core_clk, rst, powerup_reset_n, sys_reset_n, busCycle, busRead, testMode_n, strobeMask,
   input wire [23:0] busAddr,
   input wire kbdCs_n_out, kbdCs_n_oe_n, romCs_n_out, romCs_n_oe_n, kbd_reg_select,
   input wire kbd_read_strobe_n, kbd_write_strobe_n, periph_reset_n);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire kHit = busCycle && busAddr[23:16] == 8'h42 && powerup_reset_n && !kbdCs_n_oe_n;
   chk_kbd_sel: assert property (kHit |=> !kbdCs_n_out) else $error("kbd select missing");
   chk_strobe_idle: assert property (!busCycle |=> kbdCs_n_out && kbd_read_strobe_n && kbd_write_strobe_n)
      else $error("strobe outside cycle");
   chk_rom_wr: assert property (busCycle && !busRead |=> romCs_n_out) else $error("rom on write");
   chk_rom_top: assert property (busCycle && busAddr > 24'h03_FFFF |=> romCs_n_out) else $error("rom range");
   chk_rom_std: assert property (busCycle && busRead && busAddr <= 24'h01_FFFF && !romCs_n_oe_n
      |=> !romCs_n_out) else $error("rom select missing");
   chk_reg_sel: assert property (kHit |=> kbd_reg_select == $past(busAddr[1])) else $error("reg select");
   chk_wr_mask: assert property (!testMode_n && strobeMask |=> kbd_write_strobe_n) else $error("mask");
   chk_rd_wr: assert property (!kbd_read_strobe_n |-> kbd_write_strobe_n && !kbdCs_n_out) else $error("strobes");
   chk_rst_low: assert property (!powerup_reset_n || !sys_reset_n |=> !periph_reset_n) else $error("reset");
   chk_rst_len: assert property ($rose(periph_reset_n) |-> $past(powerup_reset_n, RESET_CYCLES)
      && $past(sys_reset_n, RESET_CYCLES)) else $error("reset short");
   chk_pu_tri: assert property (!powerup_reset_n |=> kbdCs_n_oe_n && romCs_n_oe_n) else $error("tri");
   cover property (!kbdCs_n_out && !kbd_write_strobe_n);
   cover property (!romCs_n_out);
   cover property ($rose(periph_reset_n));
endmodule // kbrom_decode_assertions
bind kbrom_decode kbrom_decode_assertions #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.*);

/* File: test/kbrom_pins.sv */
`timescale 1ns/1ps
// ****
// select pins with pull-ups and straps
// ****
module kbrom_pins(input wire kOut, kOe_n, kStrap, rOut, rOe_n, rStrap, output wire kPin, rPin);
   // released pin goes to its pull-up unless strapped low
   assign kPin = !kOe_n ? kOut : !kStrap;
   assign rPin = !rOe_n ? rOut : !rStrap;
endmodule // kbrom_pins

/* File: test/kbrom_decode_bench.sv */
`timescale 1ns/1ps
// ****
// bench
// ****
module kbd_rom_select_decode_bench;
   localparam RC = 8;
   reg core_clk = 0, rst = 1, powerup_reset_n = 1, sys_reset_n = 1, busCycle = 0, busRead = 0, kS = 0, rS = 0;
   reg extRomDecode = 0, testMode_n = 1, strobeMask = 0;
   reg [23:0] busAddr = 0;
   reg [15:0] r = 16'h759C;
   wire kbdCs_n_in, romCs_n_in, kbdCs_n_out, kbdCs_n_oe_n, romCs_n_out, romCs_n_oe_n, kbd_reg_select;
   wire kbd_read_strobe_n, kbd_write_strobe_n, periph_reset_n;
   int err_count = 0, compares = 0, i, n;
   logic [23:0] cor [4] = '{24'h01_FFFF, 24'h02_0000, 24'h03_FFFF, 24'h42_0002};
   kbrom_decode #(.RESET_CYCLES(RC)) u_dut (.*);
   kbrom_pins u_pins (.kOut(kbdCs_n_out), .kOe_n(kbdCs_n_oe_n), .kStrap(kS), .rOut(romCs_n_out),
      .rOe_n(romCs_n_oe_n), .rStrap(rS), .kPin(kbdCs_n_in), .rPin(romCs_n_in));
   initial forever #2 core_clk = ~core_clk;
   function [15:0] lfsr(input [15:0] x);
      lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function [3:0] expect4(input [23:0] a, input c, rd, ext, tm_n, sm);
      reg k;
      k = c && a[23:16] == 8'h42;
      expect4 = {!k, !(c && rd && a <= (ext ? 24'h03_FFFF : 24'h01_FFFF)), !(k && rd), !(k && !rd) | (!tm_n && sm)};
   endfunction
   task chk(input string nm, input [3:0] e, s);
      compares++;
      if (e !== s) begin err_count++; $display("Error %s exp %h seen %h", nm, e, s); end
   endtask
   task report_and_stop;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // straps stay one edge past release so the last sampled edge still sees them
   task pureset(input k, rr, s);
      @(posedge core_clk); kS <= k; rS <= rr; powerup_reset_n <= s; sys_reset_n <= !s;
      repeat (10) @(posedge core_clk);
      powerup_reset_n <= 1; sys_reset_n <= 1; n = 0;
      @(posedge core_clk); kS <= 0; rS <= 0;
      // sampled at the falling edge, where the registered output has settled
      while (!periph_reset_n && n < 50) begin @(negedge core_clk); n++; end
      chk("reset length", 4'h1, {3'b0, n == RC + 1});
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 0;
      pureset(1, 1, 0);
      for (i = 0; i < 2; i++)
      begin
         @(posedge core_clk); busCycle <= 1; busRead <= 1; busAddr <= i ? 24'h00_0010 : 24'h42_0002;
         @(posedge core_clk); @(negedge core_clk);
         chk("strapped", 4'hF, {kbdCs_n_oe_n & romCs_n_oe_n, kbdCs_n_out, romCs_n_out, kbd_read_strobe_n});
      end
      pureset(0, 0, 0);
      for (i = 0; i < 400; i++)
      begin
         @(posedge core_clk); r = lfsr(r);
         busAddr <= i < 4 ? cor[i] : {r[2:0] == 7 ? 8'h42 : {5'h0, r[2:0]}, r[15:0]};
         busRead <= r[3]; busCycle <= r[4] | (i < 4); extRomDecode <= r[5]; testMode_n <= r[6] | r[7]; strobeMask <= r[8];
         @(posedge core_clk); @(negedge core_clk);
         chk("selects", expect4(busAddr, busCycle, busRead, extRomDecode, testMode_n, strobeMask),
            {kbdCs_n_out, romCs_n_out, kbd_read_strobe_n, kbd_write_strobe_n});
         if (busCycle && busAddr[23:16] == 8'h42) chk("reg select", {3'b0, busAddr[1]}, {3'b0, kbd_reg_select});
         chk("drive", 4'h0, {2'b0, kbdCs_n_oe_n, romCs_n_oe_n});
      end
      pureset(0, 0, 1);
      report_and_stop;
   end
endmodule // kbd_rom_select_decode_bench
